// file: hw/hcafe_pkg.sv
// Constants, types and carrier structs for the host channel adapter front end.
// Summary of operation
// - Emulation mode only on byte multiplex channel.
// - One native address serves up to 256 lines.
// - Decode mode, set it, then raise level 3.
// - Program-serviced transfer buffers at most four bytes.
// - Cycle-steal buffers 16 bytes, runs to 255.
// - Cycle-steal inbound data goes straight to storage.
// - Outbound: attention, host read selection, then data.
// - Level 5 adapter access: check plus level 1.
// - Enabled adapter watches for its addresses, selects.
// - Good standard command other than No-op or Test I/O gets all-zero initial status.
// - Nonstandard command on block or selector: channel end.
// - Capture address and command, then level 3.
// - Data sequence moves data, ends with level 3.
// - Status sequence sends status, ends with level 3.
// - Disabled adapter passes selection to next adapter.
// - Address with bad parity is never recognised.
// - Native address 0-255, interfaces A and B separate.
// - Emulation group: low multiple of 16, high 4n-1.
// - Low above high recognises no emulation address.
// - Native address wins over emulation range.
// - Emulation addresses dead until program makes them live.
package hcafe_pkg;
  typedef enum logic [2:0] {
    ST_READY    = 3'h0,
    ST_INIT_SEL = 3'h1,
    ST_DATA     = 3'h3,
    ST_STATUS   = 3'h2,
    ST_DISABLED = 3'h6
  } hcafe_state_t;
  typedef enum logic [1:0] {
    CH_BYTE_MUX  = 2'h0,
    CH_SELECTOR  = 2'h1,
    CH_BLOCK_MUX = 2'h2
  } hcafe_chan_t;
  typedef enum logic [2:0] {
    OP_NONE         = 3'h0,
    OP_START_DATA   = 3'h1,
    OP_START_STATUS = 3'h2,
    OP_WRITE_BYTE   = 3'h3,
    OP_READ_BYTE    = 3'h4,
    OP_ACK_L3       = 3'h5,
    OP_ACK_L1       = 3'h6
  } hcafe_op_t;
  localparam logic [2:0] LVL_BACKGROUND  = 3'h5;
  localparam logic [7:0] CMD_TEST_IO     = 8'h00;
  localparam logic [7:0] CMD_NO_OP       = 8'h03;
  localparam logic [3:0] CMD_SENSE       = 4'h4;
  localparam logic [1:0] CMD_DIR_WRITE   = 2'h1;
  localparam logic [1:0] CMD_DIR_NONE    = 2'h0;
  localparam logic [7:0] STAT_ZERO       = 8'h00;
  localparam logic [7:0] STAT_CHAN_END   = 8'h08;
  localparam logic [7:0] STAT_DEV_END    = 8'h04;
  localparam logic [7:0] STAT_UNIT_CHECK = 8'h02;
  localparam logic [7:0] EMU_LOW_MASK    = 8'hf0;
  localparam logic [7:0] EMU_HIGH_FILL   = 8'h03;
  localparam int         FIFO_W          = 8;
  localparam int         FIFO_DEPTH      = 16;
  localparam int         CNT_W           = 5;
  localparam logic [4:0] PIO_FILL        = 5'h04;
  localparam logic [7:0] PIO_RUN         = 8'h04;
  typedef struct packed {
    logic select;
    logic addr_out;
    logic cmd_out;
    logic serv_out;
  } hcafe_tags_t;
  typedef struct packed {
    logic       par;
    logic [7:0] data;
  } hcafe_bus_t;
  typedef struct packed {
    logic        prog_en;
    logic        panel_en;
    logic        live;
    logic        iface_b;
    hcafe_chan_t chan;
    logic [7:0]  nsc_a;
    logic [7:0]  nsc_b;
    logic [7:0]  emu_low;
    logic [7:0]  emu_high;
  } hcafe_cfg_t;
  typedef struct packed {
    hcafe_tags_t tags;
    hcafe_bus_t  bus;
    hcafe_cfg_t  cfg;
  } hcafe_pins_t;
  typedef struct packed {
    logic       emul;
    logic [7:0] addr;
    logic [7:0] cmd;
  } hcafe_sel_t;
endpackage : hcafe_pkg

// file: hw/hcafe_fifo.sv
// Flip-flop FIFO with valid and ready on both sides and a flush.
`timescale 1ns/1ps
module hcafe_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 16,
  parameter int CW    = 5
) (
  input  wire logic          i_core_clk,
  input  wire logic          i_rst_n,
  input  wire logic          i_flush,
  input  wire logic          i_in_valid,
  output logic               o_in_ready,
  input  wire logic [W-1:0]  i_in_data,
  output logic               o_out_valid,
  input  wire logic          i_out_ready,
  output logic [W-1:0]       o_out_data,
  output logic [CW-1:0]      o_count
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0]  mem_r [DEPTH];
  logic [AW-1:0] wr_r;
  logic [AW-1:0] rd_r;
  logic [CW-1:0] cnt_r;
  logic          push;
  logic          pop;

  // Full and empty come straight from the occupancy count.
  assign o_in_ready  = (cnt_r != CW'(DEPTH));
  assign o_out_valid = (cnt_r != '0);
  assign push        = i_in_valid & o_in_ready;
  assign pop         = i_out_ready & o_out_valid;
  assign o_out_data  = mem_r[rd_r];
  assign o_count     = cnt_r;

  // Pointers wrap naturally because the depth is a power of two.
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n || i_flush) begin
      wr_r  <= '0;
      rd_r  <= '0;
      cnt_r <= '0;
    end else begin
      wr_r  <= wr_r + AW'(push);
      rd_r  <= rd_r + AW'(pop);
      cnt_r <= cnt_r + CW'(push) - CW'(pop);
    end
  end

  // Storage is written only on an accepted push.
  always_ff @(posedge i_core_clk) begin
    if (push) begin
      mem_r[wr_r] <= i_in_data;
    end
  end
endmodule : hcafe_fifo

// file: hw/hcafe_addr_dec.sv
// Device address recognition for native and emulation subchannels.
`timescale 1ns/1ps
module hcafe_addr_dec import hcafe_pkg::*; (
  input  hcafe_bus_t i_bus,
  input  hcafe_cfg_t i_cfg,
  output logic       o_nsc_hit,
  output logic       o_esc_hit
);
  logic       par_ok;
  logic [7:0] nsc_addr;
  logic [7:0] lo;
  logic [7:0] hi;
  logic       in_range;
  logic       nsc_match;

  // Odd parity over address and parity bit must hold before decoding.
  assign par_ok    = ^{i_bus.par, i_bus.data};
  // Each interface carries its own native address.
  assign nsc_addr  = i_cfg.iface_b ? i_cfg.nsc_b : i_cfg.nsc_a;
  assign nsc_match = (i_bus.data == nsc_addr);
  // Low bound snaps to a multiple of 16, high bound to 4n-1.
  assign lo        = i_cfg.emu_low & EMU_LOW_MASK;
  assign hi        = i_cfg.emu_high | EMU_HIGH_FILL;
  // An inverted group holds no address.
  assign in_range  = (lo <= hi) && (i_bus.data >= lo) && (i_bus.data <= hi);
  assign o_nsc_hit = par_ok && nsc_match;
  // Native wins; emulation needs the live bit and a byte multiplex channel.
  assign o_esc_hit = par_ok && in_range && !nsc_match
                     && i_cfg.live
                     && (i_cfg.chan == CH_BYTE_MUX);
endmodule : hcafe_addr_dec

// file: hw/hcafe_top.sv
// Host channel adapter front end: selection, data and status sequencing.
`timescale 1ns/1ps
module hcafe_top import hcafe_pkg::*; (
  input  wire logic       i_core_clk,
  input  wire logic       i_rst_n,
  input  hcafe_tags_t     i_chan_tags,
  input  hcafe_bus_t      i_chan_bus,
  input  hcafe_cfg_t      i_cfg,
  output logic            o_select_out,
  output logic            o_addr_in,
  output logic            o_status_in,
  output logic            o_serv_in,
  output hcafe_bus_t      o_bus_in,
  input  wire logic       i_cpu_req,
  input  wire logic [2:0] i_cpu_level,
  input  hcafe_op_t       i_cpu_op,
  input  wire logic [7:0] i_cpu_wdata,
  input  wire logic       i_cycle_steal,
  output logic [7:0]      o_cpu_rdata,
  output logic            o_buf_room,
  output logic            o_lvl1_irq,
  output logic            o_io_check,
  output logic            o_lvl3_irq,
  output hcafe_sel_t      o_sel_info,
  output hcafe_state_t    o_state,
  output logic            o_cs_wr_valid,
  output logic [7:0]      o_cs_wr_data,
  input  wire logic       i_cs_wr_ready,
  output logic            o_cs_rd_ready,
  input  wire logic       i_cs_rd_valid,
  input  wire logic [7:0] i_cs_rd_data
);
  hcafe_pins_t  pins_w;
  hcafe_pins_t  sync1_r;
  hcafe_pins_t  sync2_r;
  hcafe_tags_t  prev_r;
  hcafe_tags_t  tg;
  hcafe_tags_t  rise_w;
  hcafe_cfg_t   cfg;
  hcafe_state_t st_r;
  hcafe_state_t st_nxt;
  hcafe_sel_t   sel_r;
  hcafe_sel_t   sel_nxt;
  hcafe_bus_t   bus_in_r;
  hcafe_bus_t   bus_in_nxt;
  logic         ph_r;
  logic         ph_nxt;
  logic [7:0]   left_r;
  logic [7:0]   left_nxt;
  logic [7:0]   fetch_r;
  logic [7:0]   fetch_nxt;
  logic         aio_r;
  logic         aio_nxt;
  logic         serv_in_r;
  logic         serv_in_nxt;
  logic         addr_in_r;
  logic         addr_in_nxt;
  logic         status_in_r;
  logic         status_in_nxt;
  logic         lvl3_r;
  logic         lvl3_nxt;
  logic         lvl1_r;
  logic         lvl1_nxt;
  logic         io_check_r;
  logic [7:0]   rdata_r;
  logic [7:0]   rdata_nxt;
  logic         nsc_hit_w;
  logic         esc_hit_w;
  logic         hit_w;
  logic         enabled_w;
  logic         addr_take_w;
  logic         cmd_take_w;
  logic         sel_end_w;
  logic         priv_fault_w;
  logic         op_ok_w;
  logic         start_data_w;
  logic         start_stat_w;
  logic         wr_op_w;
  logic         rd_op_w;
  logic         dir_in_w;
  logic         room_w;
  logic         ch_take_w;
  logic         raise_w;
  logic         fetch_ok_w;
  logic         data_done_w;
  logic         stat_end_w;
  logic [7:0]   run_w;
  logic [7:0]   cmd_w;
  logic         cmd_par_ok_w;
  logic         std_w;
  logic         noop_tio_w;
  logic [7:0]   init_stat_w;
  logic         f_push;
  logic         f_pop;
  logic [7:0]   f_in_data;
  logic         f_in_ready;
  logic         f_out_valid;
  logic [7:0]   f_out_data;
  logic [CNT_W-1:0] f_cnt;

  // Every channel pin and strap passes two flip-flops before use.
  assign pins_w = '{tags: i_chan_tags, bus: i_chan_bus, cfg: i_cfg};
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      sync1_r <= '0;
      sync2_r <= '0;
      prev_r  <= '0;
    end else begin
      sync1_r <= pins_w;
      sync2_r <= sync1_r;
      prev_r  <= sync2_r.tags;
    end
  end

  // Synchronised views and tag edges.
  assign tg        = sync2_r.tags;
  assign cfg       = sync2_r.cfg;
  assign rise_w    = tg & ~prev_r;
  assign enabled_w = cfg.prog_en | cfg.panel_en;

  hcafe_addr_dec u_dec (
    .i_bus     (sync2_r.bus),
    .i_cfg     (cfg),
    .o_nsc_hit (nsc_hit_w),
    .o_esc_hit (esc_hit_w)
  );

  // Selection handshake decode on the channel side.
  assign hit_w       = nsc_hit_w | esc_hit_w;
  assign addr_take_w = (st_r == ST_READY) & enabled_w & tg.select & rise_w.addr_out & hit_w;
  assign cmd_take_w  = (st_r == ST_INIT_SEL) & ~ph_r & rise_w.cmd_out;
  assign sel_end_w   = (st_r == ST_INIT_SEL) & ph_r & rise_w.serv_out;
  // Selection passes on when disabled, or when ready and this adapter does not claim it.
  assign o_select_out = tg.select & ((st_r == ST_DISABLED)
                        | ((st_r == ST_READY) & ~(hit_w & tg.addr_out)));

  // Initial status from the command byte and its parity.
  assign cmd_w        = sync2_r.bus.data;
  assign cmd_par_ok_w = ^{sync2_r.bus.par, cmd_w};
  assign std_w        = (cmd_w[1:0] != CMD_DIR_NONE) | (cmd_w[3:0] == CMD_SENSE) | (cmd_w == CMD_TEST_IO);
  assign noop_tio_w   = (cmd_w == CMD_NO_OP) | (cmd_w == CMD_TEST_IO);
  assign init_stat_w  = !cmd_par_ok_w ? STAT_UNIT_CHECK
                      : noop_tio_w ? (STAT_CHAN_END | STAT_DEV_END)
                      : std_w ? STAT_ZERO
                      : (cfg.chan != CH_BYTE_MUX) ? STAT_CHAN_END
                      : STAT_UNIT_CHECK;

  // Processor side decode; background level access is refused.
  assign priv_fault_w = i_cpu_req & (i_cpu_level == LVL_BACKGROUND);
  assign op_ok_w      = i_cpu_req & ~priv_fault_w;
  assign start_data_w = op_ok_w & (i_cpu_op == OP_START_DATA) & (st_r == ST_READY) & ~addr_take_w;
  assign start_stat_w = op_ok_w & (i_cpu_op == OP_START_STATUS) & (st_r == ST_READY) & ~addr_take_w;
  assign wr_op_w      = op_ok_w & (i_cpu_op == OP_WRITE_BYTE) & (st_r == ST_DATA);
  assign rd_op_w      = op_ok_w & (i_cpu_op == OP_READ_BYTE) & (st_r == ST_DATA);

  // Run length: at most four bytes per program service, up to 255 by cycle steal.
  assign run_w = i_cycle_steal ? i_cpu_wdata
               : ((i_cpu_wdata > PIO_RUN) ? PIO_RUN : i_cpu_wdata);

  // Direction follows the captured command.
  assign dir_in_w = (sel_r.cmd[1:0] == CMD_DIR_WRITE);
  // Program mode holds at most four bytes in the buffer.
  assign room_w   = aio_r ? f_in_ready : (f_cnt < PIO_FILL);
  assign ch_take_w = (st_r == ST_DATA) & serv_in_r & rise_w.serv_out;
  assign raise_w   = (st_r == ST_DATA) & enabled_w & ~serv_in_r & ~tg.serv_out
                   & (left_r != '0) & (dir_in_w ? room_w : f_out_valid);
  assign fetch_ok_w = (st_r == ST_DATA) & ~dir_in_w & (fetch_r != '0) & room_w;
  assign data_done_w = (st_r == ST_DATA) & (left_r == '0) & ~serv_in_r
                     & (~dir_in_w | ~f_out_valid);
  assign stat_end_w  = (st_r == ST_STATUS) & status_in_r & rise_w.serv_out;

  // Buffer filling side: host byte, storage fetch or program write.
  assign f_push    = dir_in_w ? ch_take_w
                   : aio_r ? (i_cs_rd_valid & o_cs_rd_ready)
                   : (wr_op_w & fetch_ok_w);
  assign f_in_data = dir_in_w ? cmd_w : (aio_r ? i_cs_rd_data : i_cpu_wdata);
  // Buffer draining side: storage write, program read or the channel.
  assign f_pop     = dir_in_w ? (aio_r ? ((st_r == ST_DATA) & i_cs_wr_ready) : rd_op_w)
                   : (raise_w & ~dir_in_w);

  hcafe_fifo #(
    .W     (FIFO_W),
    .DEPTH (FIFO_DEPTH),
    .CW    (CNT_W)
  ) u_fifo (
    .i_core_clk  (i_core_clk),
    .i_rst_n     (i_rst_n),
    .i_flush     (start_data_w),
    .i_in_valid  (f_push),
    .o_in_ready  (f_in_ready),
    .i_in_data   (f_in_data),
    .o_out_valid (f_out_valid),
    .i_out_ready (f_pop),
    .o_out_data  (f_out_data),
    .o_count     (f_cnt)
  );

  // Inbound cycle-steal bytes go straight to main storage.
  assign o_cs_wr_valid = (st_r == ST_DATA) & dir_in_w & aio_r & f_out_valid;
  assign o_cs_wr_data  = f_out_data;
  assign o_cs_rd_ready = fetch_ok_w & aio_r;
  assign o_buf_room    = fetch_ok_w & ~aio_r;

  // State sequencing; host selection wins over a program start.
  always_comb begin
    st_nxt = st_r;
    if (!enabled_w) begin
      st_nxt = ST_DISABLED;
    end else begin
      case (st_r)
        ST_READY: begin
          if (addr_take_w) begin
            st_nxt = ST_INIT_SEL;
          end else if (start_data_w) begin
            st_nxt = ST_DATA;
          end else if (start_stat_w) begin
            st_nxt = ST_STATUS;
          end
        end
        ST_INIT_SEL: begin
          if (sel_end_w) begin
            st_nxt = ST_READY;
          end
        end
        ST_DATA: begin
          if (data_done_w) begin
            st_nxt = ST_READY;
          end
        end
        ST_STATUS: begin
          if (stat_end_w) begin
            st_nxt = ST_READY;
          end
        end
        default: st_nxt = ST_READY;
      endcase
    end
  end

  // Selection capture: address and mode first, then the command.
  assign ph_nxt = (st_r == ST_INIT_SEL) & (ph_r | cmd_take_w);
  assign sel_nxt = addr_take_w ? hcafe_sel_t'{emul: esc_hit_w, addr: cmd_w, cmd: sel_r.cmd}
                 : cmd_take_w ? hcafe_sel_t'{emul: sel_r.emul, addr: sel_r.addr, cmd: cmd_w}
                 : sel_r;

  // Channel tag outputs, each dropped when the adapter is disabled.
  assign addr_in_nxt   = addr_take_w | (addr_in_r & ~cmd_take_w & enabled_w);
  assign status_in_nxt = (cmd_take_w | start_stat_w
                       | (status_in_r & ~sel_end_w & ~stat_end_w)) & enabled_w;
  assign serv_in_nxt   = raise_w | (serv_in_r & ~ch_take_w & enabled_w);

  // Byte shown to the host, with odd parity added.
  assign bus_in_nxt.data = addr_take_w ? cmd_w
                         : cmd_take_w ? init_stat_w
                         : start_stat_w ? i_cpu_wdata
                         : (raise_w & ~dir_in_w) ? f_out_data
                         : bus_in_r.data;
  assign bus_in_nxt.par  = ~^bus_in_nxt.data;

  // Byte counts for the channel and for the filling side.
  assign left_nxt  = start_data_w ? run_w : (ch_take_w ? left_r - 8'h01 : left_r);
  assign fetch_nxt = start_data_w ? run_w
                   : ((f_push & ~dir_in_w) ? fetch_r - 8'h01 : fetch_r);
  assign aio_nxt   = start_data_w ? i_cycle_steal : aio_r;

  // Sticky interrupts; a new event beats a same-cycle clear.
  assign lvl3_nxt = sel_end_w | data_done_w | stat_end_w
                  | (lvl3_r & ~(op_ok_w & (i_cpu_op == OP_ACK_L3)));
  assign lvl1_nxt = priv_fault_w | (lvl1_r & ~(op_ok_w & (i_cpu_op == OP_ACK_L1)));
  assign rdata_nxt = (rd_op_w & dir_in_w & ~aio_r & f_out_valid) ? f_out_data : rdata_r;

  // Sequencer registers.
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      st_r  <= ST_READY;
      ph_r  <= 1'b0;
      sel_r <= '0;
      aio_r <= 1'b0;
    end else begin
      st_r  <= st_nxt;
      ph_r  <= ph_nxt;
      sel_r <= sel_nxt;
      aio_r <= aio_nxt;
    end
  end

  // Channel-facing output registers.
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      addr_in_r   <= 1'b0;
      status_in_r <= 1'b0;
      serv_in_r   <= 1'b0;
      bus_in_r    <= '0;
    end else begin
      addr_in_r   <= addr_in_nxt;
      status_in_r <= status_in_nxt;
      serv_in_r   <= serv_in_nxt;
      bus_in_r    <= bus_in_nxt;
    end
  end

  // Counters, interrupts and read data.
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      left_r     <= '0;
      fetch_r    <= '0;
      lvl3_r     <= 1'b0;
      lvl1_r     <= 1'b0;
      io_check_r <= 1'b0;
      rdata_r    <= '0;
    end else begin
      left_r     <= left_nxt;
      fetch_r    <= fetch_nxt;
      lvl3_r     <= lvl3_nxt;
      lvl1_r     <= lvl1_nxt;
      io_check_r <= priv_fault_w;
      rdata_r    <= rdata_nxt;
    end
  end

  // Output map.
  assign o_addr_in   = addr_in_r;
  assign o_status_in = status_in_r;
  assign o_serv_in   = serv_in_r;
  assign o_bus_in    = bus_in_r;
  assign o_cpu_rdata = rdata_r;
  assign o_lvl1_irq  = lvl1_r;
  assign o_io_check  = io_check_r;
  assign o_lvl3_irq  = lvl3_r;
  assign o_sel_info  = sel_r;
  assign o_state     = st_r;

  // Checks on the sequencer.
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);

  property p_priv;
    priv_fault_w |=> lvl1_r && io_check_r ##1 lvl1_r;
  endproperty
  a_priv: assert property (p_priv) else $error("Background access missed level 1.");

  property p_pass;
    (st_r == ST_DISABLED) |-> (o_select_out == tg.select);
  endproperty
  a_pass: assert property (p_pass) else $error("Disabled adapter blocked selection.");

  property p_mode;
    addr_take_w |=> (sel_r.emul == $past(esc_hit_w)) && (st_r == ST_INIT_SEL) && addr_in_r;
  endproperty
  a_mode: assert property (p_mode) else $error("Mode not set at selection.");

  property p_capture;
    cmd_take_w && enabled_w |=> (sel_r.cmd == $past(cmd_w)) && status_in_r && !addr_in_r;
  endproperty
  a_capture: assert property (p_capture) else $error("Command not captured.");

  property p_sel_irq;
    sel_end_w && enabled_w |=> lvl3_r && (st_r == ST_READY) && !status_in_r;
  endproperty
  a_sel_irq: assert property (p_sel_irq) else $error("Selection end without level 3.");

  property p_data_irq;
    data_done_w && enabled_w |=> lvl3_r && (st_r == ST_READY);
  endproperty
  a_data_irq: assert property (p_data_irq) else $error("Data end without level 3.");

  property p_stat_irq;
    stat_end_w && enabled_w |=> !status_in_r && lvl3_r;
  endproperty
  a_stat_irq: assert property (p_stat_irq) else $error("Status end without level 3.");

  property p_pio_fill;
    (st_r == ST_DATA) && !aio_r |-> (f_cnt <= PIO_FILL);
  endproperty
  a_pio_fill: assert property (p_pio_fill) else $error("Program buffer above four bytes.");

  property p_run;
    start_data_w && i_cycle_steal |=> (left_r == $past(i_cpu_wdata)) && aio_r;
  endproperty
  a_run: assert property (p_run) else $error("Cycle-steal run length wrong.");

  property p_zero_stat;
    cmd_take_w && enabled_w && cmd_par_ok_w && std_w && !noop_tio_w |=> (bus_in_r.data == STAT_ZERO);
  endproperty
  a_zero_stat: assert property (p_zero_stat) else $error("Initial status not zero.");

  property p_ce_stat;
    cmd_take_w && enabled_w && cmd_par_ok_w && !std_w && (cfg.chan != CH_BYTE_MUX)
      |=> (bus_in_r.data == STAT_CHAN_END);
  endproperty
  a_ce_stat: assert property (p_ce_stat) else $error("Nonstandard command not channel end.");

  property p_parity;
    !(^{sync2_r.bus.par, cmd_w}) |-> !nsc_hit_w && !esc_hit_w;
  endproperty
  a_parity: assert property (p_parity) else $error("Bad-parity address recognised.");

  property p_native_wins;
    nsc_hit_w |-> !esc_hit_w;
  endproperty
  a_native_wins: assert property (p_native_wins) else $error("Native address used by emulation.");

  property p_live;
    !cfg.live || (cfg.chan != CH_BYTE_MUX) |-> !esc_hit_w;
  endproperty
  a_live: assert property (p_live) else $error("Emulation address recognised early.");
endmodule : hcafe_top

// file: sim/hcafe_host_model.sv
// Host channel model that selects the adapter and takes status.
`timescale 1ns/1ps
module hcafe_host_model import hcafe_pkg::*; (
  input  wire logic   i_core_clk,
  input  wire logic   i_addr_in,
  input  wire logic   i_status_in,
  input  wire logic   i_serv_in,
  input  hcafe_bus_t  i_bus_in,
  output hcafe_tags_t o_tags,
  output hcafe_bus_t  o_bus
);
  // Idle channel: tags low.
  initial begin
    o_tags = '0;
    o_bus = 9'h100;
  end
  // Waits for status, takes it with serv_out, drops once status_in falls.
  task automatic ack_status(output logic [7:0] st);
    for (int n = 0; n < 40 && i_status_in !== 1'b1; n++) @(posedge i_core_clk);
    st = i_bus_in.data;
    o_tags <= {o_tags.select, 3'b001};
    o_bus <= ~o_bus;
    for (int n = 0; n < 40 && i_status_in === 1'b1; n++) @(posedge i_core_clk);
    o_tags <= '0;
  endtask : ack_status
  // Answers one service request with a byte, then lets the bus go once serv_in falls.
  task automatic give_byte(input logic [7:0] d);
    for (int n = 0; n < 40 && i_serv_in !== 1'b1; n++) @(posedge i_core_clk);
    o_bus <= {~^d, d};
    o_tags <= 4'b0001;
    for (int n = 0; n < 40 && i_serv_in === 1'b1; n++) @(posedge i_core_clk);
    o_tags <= '0;
    o_bus <= ~o_bus;
  endtask : give_byte
  // Address then command; a refused address is dropped after 40 cycles.
  task automatic select_dev(input logic [7:0] a, input logic [7:0] c, input logic bad,
                            output logic ans, output logic [7:0] st);
    @(posedge i_core_clk);
    o_bus <= {~^a ^ bad, a};
    o_tags <= 4'b1100;
    for (int n = 0; n < 40 && i_addr_in !== 1'b1; n++) @(posedge i_core_clk);
    ans = (i_addr_in === 1'b1);
    st = 8'h00;
    if (ans) begin
      o_tags <= 4'b1010;
      o_bus <= {~^c, c};
      ack_status(st);
    end else begin
      o_tags <= '0;
      o_bus <= ~o_bus;
    end
  endtask : select_dev
endmodule : hcafe_host_model

// file: sim/tb_top.sv
// Self-checking bench for the host channel adapter front end.
`timescale 1ns/1ps
module tb_top;
  import hcafe_pkg::*;
  logic         clk = 1'b0;
  logic         rst_n = 1'b0;
  logic         req = 1'b0;
  logic         cs = 1'b0;
  logic         rd_vld = 1'b0;
  logic [2:0]   lvl = 3'h3;
  logic [7:0]   wd = 8'h00;
  hcafe_op_t    op = OP_NONE;
  hcafe_cfg_t   cfg;
  hcafe_tags_t  tags;
  hcafe_bus_t   bus;
  hcafe_bus_t   bus_in;
  logic         sel_out;
  logic         addr_in;
  logic         st_in;
  logic         serv_in;
  logic [7:0]   rdata;
  logic         l1;
  logic         chk_p;
  logic         l3;
  hcafe_sel_t   sinfo;
  hcafe_state_t state;
  int           miscompares = 0;
  int           check_count = 0;
  // Core clock, 25 ns.
  always #12.5 clk = ~clk;
  hcafe_top i_dut (.i_core_clk(clk), .i_rst_n(rst_n), .i_chan_tags(tags), .i_chan_bus(bus), .i_cfg(cfg),
    .o_select_out(sel_out), .o_addr_in(addr_in), .o_status_in(st_in), .o_serv_in(serv_in), .o_bus_in(bus_in),
    .i_cpu_req(req), .i_cpu_level(lvl), .i_cpu_op(op), .i_cpu_wdata(wd), .i_cycle_steal(cs),
    .o_cpu_rdata(rdata), .o_buf_room(), .o_lvl1_irq(l1), .o_io_check(chk_p), .o_lvl3_irq(l3),
    .o_sel_info(sinfo), .o_state(state), .o_cs_wr_valid(), .o_cs_wr_data(), .i_cs_wr_ready(1'b1),
    .o_cs_rd_ready(), .i_cs_rd_valid(rd_vld), .i_cs_rd_data(wd));
  hcafe_host_model i_host (.i_core_clk(clk), .i_addr_in(addr_in), .i_status_in(st_in), .i_serv_in(serv_in),
    .i_bus_in(bus_in), .o_tags(tags), .o_bus(bus));
  task automatic tally_and_finish;
    if (miscompares == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : tally_and_finish
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic cpu(input logic [2:0] l, input hcafe_op_t o, input logic [7:0] d);
    @(posedge clk);
    req <= 1'b1;
    lvl <= l;
    op <= o;
    wd <= d;
    @(posedge clk);
    req <= 1'b0;
    op <= OP_NONE;
  endtask : cpu
  // One selection; a refused one must pass select on.
  task automatic sel(input logic [7:0] a, input logic [7:0] c, input logic bad, input logic ea,
                     input logic [7:0] es);
    logic       ans;
    logic [7:0] st;
    fork
      i_host.select_dev(a, c, bad, ans, st);
      begin
        repeat (12) @(posedge clk);
        if (!ea) chk("select_out", 8'h1, {7'h0, sel_out});
      end
    join
    repeat (2) @(posedge clk);
    chk("answered", {7'h0, ea}, {7'h0, ans});
    if (ea) begin
      chk("status", es, st);
      chk("lvl3", 8'h1, {7'h0, l3});
      chk("sel_addr", a, sinfo.addr);
      chk("sel_cmd", c, sinfo.cmd);
      cpu(3'h3, OP_ACK_L3, 8'h00);
    end
  endtask : sel
  task automatic t_status;
    logic [7:0] st;
    cpu(3'h3, OP_START_STATUS, 8'h0c);
    i_host.ack_status(st);
    repeat (2) @(posedge clk);
    chk("status_byte", 8'h0c, st);
    chk("status_lvl3", 8'h1, {7'h0, l3});
    cpu(3'h3, OP_ACK_L3, 8'h00);
  endtask : t_status
  task automatic t_priv;
    logic seen;
    cpu(LVL_BACKGROUND, OP_START_STATUS, 8'h0c);
    #1 seen = chk_p;
    @(posedge clk);
    #1 seen = seen | chk_p;
    chk("io_check", 8'h1, {7'h0, seen});
    chk("lvl1", 8'h1, {7'h0, l1});
    chk("state", {5'h0, ST_READY}, {5'h0, state});
  endtask : t_priv
  // Inbound program-serviced run of six is cut to four; the run ends only when the program has read all four.
  task automatic t_data;
    sel(8'h42, 8'h01, 1'b0, 1'b1, STAT_ZERO);
    cpu(3'h3, OP_START_DATA, 8'h06);
    for (int i = 0; i < 4; i++) i_host.give_byte(8'ha0 + 8'(i));
    for (int i = 0; i < 4; i++) begin
      cpu(3'h3, OP_READ_BYTE, 8'h00);
      #1 chk("rdata", 8'ha0 + 8'(i), rdata);
    end
    repeat (2) @(posedge clk);
    chk("data_lvl3", 8'h1, {7'h0, l3});
    chk("data_state", {5'h0, ST_READY}, {5'h0, state});
    cpu(3'h3, OP_ACK_L3, 8'h00);
  endtask : t_data
  // Watchdog.
  initial begin
    #1000000;
    miscompares++;
    tally_and_finish();
  end
  // Main sequence.
  initial begin
    cfg = '0;
    cfg.prog_en = 1'b1;
    cfg.chan = CH_SELECTOR;
    cfg.nsc_a = 8'h42;
    cfg.emu_low = 8'h20;
    cfg.emu_high = 8'h2f;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    repeat (6) @(posedge clk);
    sel(8'h42, 8'h01, 1'b0, 1'b1, STAT_ZERO);
    sel(8'h42, CMD_NO_OP, 1'b0, 1'b1, 8'h0c);
    sel(8'h42, 8'h01, 1'b1, 1'b0, 8'h00);
    sel(8'h42, 8'h08, 1'b0, 1'b1, STAT_CHAN_END);
    t_status();
    t_priv();
    t_data();
    cfg.live <= 1'b1;
    sel(8'h24, 8'h02, 1'b0, 1'b0, 8'h00);
    cfg.chan <= CH_BYTE_MUX;
    sel(8'h24, 8'h02, 1'b0, 1'b1, STAT_ZERO);
    chk("emul", 8'h1, {7'h0, sinfo.emul});
    cfg.nsc_a <= 8'h24;
    sel(8'h24, 8'h02, 1'b0, 1'b1, STAT_ZERO);
    chk("native", 8'h0, {7'h0, sinfo.emul});
    cfg.emu_low <= 8'h30;
    cfg.emu_high <= 8'h23;
    sel(8'h30, 8'h02, 1'b0, 1'b0, 8'h00);
    cfg.emu_low <= 8'h20;
    cfg.emu_high <= 8'h2f;
    cfg.live <= 1'b0;
    sel(8'h28, 8'h02, 1'b0, 1'b0, 8'h00);
    cfg.prog_en <= 1'b0;
    repeat (8) @(posedge clk);
    chk("disabled", {5'h0, ST_DISABLED}, {5'h0, state});
    sel(8'h24, 8'h01, 1'b0, 1'b0, 8'h00);
    tally_and_finish();
  end
endmodule : tb_top
